// ==== rtl/amcs_conv_if.sv ====
// handshake between the sequencer and the converter cycle timer
`timescale 1ns/1ps
interface amcs_conv_if (
	input wire logic clk, // system clock
	input wire logic reset // asynchronous reset, active high
);
	logic start;
	logic [amcs_pkg::CYC_W-1:0] cycles;
	logic busy;
	logic done;

	modport ctrl (input clk, input reset, output start, output cycles, input busy, input done);
	modport timer (input clk, input reset, input start, input cycles, output busy, output done);
endinterface

// ==== rtl/amcs_conv_timer.sv ====
// counts converter clock cycles for one conversion or calibration step
`timescale 1ns/1ps
module amcs_conv_timer (
	amcs_conv_if.timer bus // start, length, busy and done
);
	logic [amcs_pkg::DIV_W-1:0] div;
	logic [amcs_pkg::CYC_W-1:0] cnt;
	logic [amcs_pkg::CYC_W-1:0] len;
	logic [15:0] elapsed;
	logic div_wrap;

	assign div_wrap = (div == amcs_pkg::DIV_W'(amcs_pkg::CONV_DIV_CYCLES - 1));

	// a new start restarts the count; a step abandoned without a new start still runs on to done
	always_ff @(posedge bus.clk or posedge bus.reset)
	begin
		if (bus.reset)
		begin
			div <= '0;
			cnt <= '0;
			len <= '0;
			bus.busy <= 1'b0;
			bus.done <= 1'b0;
		end
		else
		begin
			bus.done <= 1'b0;
			if (bus.start)
			begin
				div <= '0;
				cnt <= bus.cycles;
				len <= bus.cycles;
				bus.busy <= 1'b1;
			end
			else if (bus.busy)
			begin
				div <= div_wrap ? '0 : div + 1'b1;
				if (div_wrap)
				begin
					cnt <= cnt - 1'b1;
					if (cnt == 3'h1)
					begin
						bus.busy <= 1'b0;
						bus.done <= 1'b1;
					end
				end
			end
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	always_ff @(posedge bus.clk or posedge bus.reset)
	begin
		if (bus.reset)
			elapsed <= '0;
		else if (bus.start)
			elapsed <= 16'h0000;
		else if (bus.busy)
			elapsed <= elapsed + 1'b1;
	end

	property p_step_length;
		@(posedge bus.clk) disable iff (bus.reset)
		bus.done |-> elapsed == 16'(32'(len) * amcs_pkg::CONV_DIV_CYCLES);
	endproperty
	a_step_length: assert property (p_step_length) else $error("step length wrong");

endmodule

// ==== rtl/amcs_mode_sequencer.sv ====
// mode and calibration sequencer for a three-channel sigma-delta converter
//
// Function
// - low-power-plus forces current gain 512
// - op 000 powers down converters and reference
// - op 001 converts enabled channels continuously
// - op 010 converts once, then goes idle
// - conversion takes two or three converter clocks
// - op 011 powered but held in reset
// - op 100 offset calibration on internal zero
// - offset calibration settles like one conversion
// - offset result written to offset register
// - offset end: idle, calibration and ready set
// - op 101 two-stage gain calibration, double time
// - gain result written to gain register
// - gain end: idle, calibration and ready set
// - factory coefficients load for voltage, temperature
// - op 110 system zero, three cycles, external
// - op 111 system full scale, external level
// - low power fixes gain 128, slow oscillator
// - mode register eight bits, resets zero
// - result read clears every ready bit
`timescale 1ns/1ps
module amcs_mode_sequencer (
	input wire logic clk, // system clock, 250 MHz
	input wire logic reset, // asynchronous reset, active high
	input wire logic mode_wr, // one-cycle write strobe of the mode register
	input wire logic [7:0] mode_wdata, // value written to the mode register
	input wire logic [3:0] gain_prog, // current-channel gain set by software
	input wire logic chop_en, // chopping active, lengthens a conversion
	input wire logic [amcs_pkg::CH_N-1:0] ch_en, // per-channel converter enable
	input wire logic [amcs_pkg::CH_N-1:0][amcs_pkg::DATA_W-1:0] sample, // modulator output
	input wire logic [amcs_pkg::DATA_W-1:0] factory_off_v, // stored voltage offset
	input wire logic [amcs_pkg::DATA_W-1:0] factory_gain_v, // stored voltage gain
	input wire logic [amcs_pkg::DATA_W-1:0] factory_off_t, // stored temperature offset
	input wire logic [amcs_pkg::DATA_W-1:0] factory_gain_t, // stored temperature gain
	input wire logic result_rd, // one-cycle pulse: software reads current result
	output logic [7:0] mode_reg, // converter mode register
	output logic [3:0] eff_gain, // gain applied to the current channel
	output logic lp_osc_sel, // converter clocked from low-power oscillator
	output logic ref_power_down, // internal reference powered down
	output logic [amcs_pkg::CH_N-1:0] conv_power_down, // converter powered down
	output logic conv_hold_reset, // converters powered but held in reset
	output logic conv_active, // a conversion or calibration step runs
	output logic [1:0] cal_source, // input select: signal, zero, reference, pins
	output logic [amcs_pkg::CH_N-1:0][amcs_pkg::DATA_W-1:0] offset_cal, // offset cal registers
	output logic [amcs_pkg::CH_N-1:0][amcs_pkg::DATA_W-1:0] gain_cal, // gain cal registers
	output logic [amcs_pkg::DATA_W-1:0] current_result, // current result register
	output logic [amcs_pkg::CH_N-1:0] ready, // per-channel result ready status
	output logic cal_status // calibration finished status
);

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [2:0] step_cycles(input logic [2:0] op_f, input logic chop_f);
		if (op_f == amcs_pkg::OP_SYS_ZERO || op_f == amcs_pkg::OP_SYS_FULL)
			return amcs_pkg::SYS_CAL_CYC;
		return chop_f ? amcs_pkg::CONV_CYC_CHOP : amcs_pkg::CONV_CYC_PLAIN;
	endfunction

	amcs_conv_if conv (.clk(clk), .reset(reset));
	amcs_conv_timer u_timer (.bus(conv.timer));

	amcs_pkg::amcs_state_t state;
	amcs_pkg::amcs_state_t next_state;
	logic next_start;
	logic stage;
	logic [amcs_pkg::CH_N-1:0][amcs_pkg::DATA_W-1:0] zero_sample;

	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	wire logic [2:0] op;
	wire logic [1:0] pwr;
	wire logic op_runs;
	wire logic fin;
	wire logic done_cont;
	wire logic done_single;
	wire logic done_off;
	wire logic done_gain1;
	wire logic done_gain2;
	wire logic done_sz;
	wire logic done_sf;
	wire logic cal_end;
	wire logic [amcs_pkg::CH_N-1:0] set_ready;
	wire logic [3:0] next_gain;
	wire logic [1:0] next_source;

	assign op = mode_reg[amcs_pkg::OP_MSB:amcs_pkg::OP_LSB];
	assign pwr = mode_reg[amcs_pkg::PWR_MSB:amcs_pkg::PWR_LSB];
	assign op_runs = (op == amcs_pkg::OP_CONT) || (op == amcs_pkg::OP_SINGLE) || op[2];
	// a mode write during a step abandons it, so its result is never stored
	assign fin = (state == amcs_pkg::ST_BUSY) && conv.done && !mode_wr;
	assign done_cont = fin && (op == amcs_pkg::OP_CONT);
	assign done_single = fin && (op == amcs_pkg::OP_SINGLE);
	assign done_off = fin && (op == amcs_pkg::OP_SELF_OFFSET);
	assign done_gain1 = fin && (op == amcs_pkg::OP_SELF_GAIN) && !stage;
	assign done_gain2 = fin && (op == amcs_pkg::OP_SELF_GAIN) && stage;
	assign done_sz = fin && (op == amcs_pkg::OP_SYS_ZERO);
	assign done_sf = fin && (op == amcs_pkg::OP_SYS_FULL);
	assign cal_end = done_off || done_gain2 || done_sz || done_sf;
	assign set_ready = {amcs_pkg::CH_N{done_cont || done_single || cal_end}} & ch_en;
	assign next_gain = (pwr == amcs_pkg::PWR_LOWPLUS) ? amcs_pkg::GAIN_512 :
		(pwr == amcs_pkg::PWR_LOW) ? amcs_pkg::GAIN_128 : gain_prog;
	assign next_source = (op == amcs_pkg::OP_SELF_OFFSET) ? amcs_pkg::SRC_INT_ZERO :
		(op == amcs_pkg::OP_SELF_GAIN) ? (stage ? amcs_pkg::SRC_INT_REF :
		amcs_pkg::SRC_INT_ZERO) :
		op[2] && op[1] ? amcs_pkg::SRC_EXTERNAL : amcs_pkg::SRC_SIGNAL;

	assign conv.start = next_start;
	assign conv.cycles = step_cycles(op, chop_en);

	// -------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_start = 1'b0;
		unique case (state)
			amcs_pkg::ST_LOAD:
				next_state = amcs_pkg::ST_STEADY;
			amcs_pkg::ST_STEADY:
				if (!mode_wr && op_runs && (ch_en != '0))
				begin
					next_start = 1'b1;
					next_state = amcs_pkg::ST_BUSY;
				end
			amcs_pkg::ST_BUSY:
				if (mode_wr)
					next_state = amcs_pkg::ST_STEADY;
				else if (done_cont || done_gain1)
					next_start = 1'b1;
				else if (fin)
					next_state = amcs_pkg::ST_STEADY;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= amcs_pkg::ST_LOAD;
			stage <= 1'b0;
			conv_active <= 1'b0;
		end
		else
		begin
			state <= next_state;
			conv_active <= (next_state == amcs_pkg::ST_BUSY);
			stage <= done_gain1 ? 1'b1 : (mode_wr || cal_end) ? 1'b0 : stage;
		end
	end

	// -------------------------------------------------------------
	// mode register and power controls
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mode_reg <= amcs_pkg::MODE_RESET;
		else if (mode_wr)
			mode_reg <= mode_wdata;
		else if (done_single || cal_end)
			mode_reg[amcs_pkg::OP_MSB:amcs_pkg::OP_LSB] <= amcs_pkg::OP_IDLE;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			eff_gain <= 4'h0;
			lp_osc_sel <= 1'b0;
			ref_power_down <= 1'b1;
			conv_power_down <= '1;
			conv_hold_reset <= 1'b0;
			cal_source <= amcs_pkg::SRC_SIGNAL;
		end
		else
		begin
			eff_gain <= next_gain;
			lp_osc_sel <= (pwr == amcs_pkg::PWR_LOW);
			ref_power_down <= (op == amcs_pkg::OP_OFF);
			conv_power_down <= {amcs_pkg::CH_N{op == amcs_pkg::OP_OFF}} | ~ch_en;
			conv_hold_reset <= (op == amcs_pkg::OP_IDLE);
			cal_source <= next_source;
		end
	end

	// -------------------------------------------------------------
	// results, calibration registers, status
	// -------------------------------------------------------------
	// voltage and temperature coefficients come from nonvolatile storage
	// once, in the first cycle after reset; the current channel starts at zero
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			offset_cal <= {amcs_pkg::CH_N{amcs_pkg::CAL_RESET}};
			gain_cal <= {amcs_pkg::CH_N{amcs_pkg::CAL_RESET}};
			zero_sample <= {amcs_pkg::CH_N{amcs_pkg::CAL_RESET}};
		end
		else if (state == amcs_pkg::ST_LOAD)
		begin
			offset_cal[amcs_pkg::CH_V] <= factory_off_v;
			gain_cal[amcs_pkg::CH_V] <= factory_gain_v;
			offset_cal[amcs_pkg::CH_T] <= factory_off_t;
			gain_cal[amcs_pkg::CH_T] <= factory_gain_t;
		end
		else
		begin
			for (int c = 0; c < amcs_pkg::CH_N; c++)
			begin
				if (ch_en[c])
				begin
					if (done_off || done_sz)
						offset_cal[c] <= sample[c];
					if (done_gain1)
						zero_sample[c] <= sample[c];
					if (done_gain2)
						gain_cal[c] <= sample[c] - zero_sample[c];
					if (done_sf)
						gain_cal[c] <= sample[c];
				end
			end
		end
	end

	// a new result or calibration end wins over a read in the same cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			current_result <= amcs_pkg::RESULT_RESET;
			ready <= '0;
			cal_status <= 1'b0;
		end
		else
		begin
			if ((done_cont || done_single) && ch_en[amcs_pkg::CH_I])
				current_result <= sample[amcs_pkg::CH_I];
			ready <= set_ready | (result_rd ? '0 : ready);
			cal_status <= cal_end | (mode_wr ? 1'b0 : cal_status);
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_lowplus_gain;
		pwr == amcs_pkg::PWR_LOWPLUS |=> eff_gain == amcs_pkg::GAIN_512;
	endproperty
	a_lowplus_gain: assert property (p_lowplus_gain) else $error("gain not 512");

	property p_low_gain;
		pwr == amcs_pkg::PWR_LOW |=> eff_gain == amcs_pkg::GAIN_128 && lp_osc_sel;
	endproperty
	a_low_gain: assert property (p_low_gain) else $error("low power setup wrong");

	property p_power_down;
		op == amcs_pkg::OP_OFF && state != amcs_pkg::ST_BUSY
		|=> ref_power_down && conv_power_down == '1 && !conv_active;
	endproperty
	a_power_down: assert property (p_power_down) else $error("not powered down");

	property p_idle_hold;
		op == amcs_pkg::OP_IDLE |=> conv_hold_reset && !ref_power_down;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle not held");

	property p_single_idle;
		done_single |=> op == amcs_pkg::OP_IDLE && !conv_active ##1 !conv_active;
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("single not idle");

	property p_cont_restart;
		done_cont |-> conv.start ##1 conv_active ##1 (conv_active || $past(mode_wr));
	endproperty
	a_cont_restart: assert property (p_cont_restart) else $error("no restart");

	property p_offset_store;
		done_off && ch_en[amcs_pkg::CH_I]
		|=> offset_cal[amcs_pkg::CH_I] == $past(sample[amcs_pkg::CH_I]);
	endproperty
	a_offset_store: assert property (p_offset_store) else $error("offset not stored");

	property p_cal_status;
		cal_end |=> cal_status && op == amcs_pkg::OP_IDLE && ((ready & $past(ch_en)) == $past(ch_en));
	endproperty
	a_cal_status: assert property (p_cal_status) else $error("status after cal");

	property p_gain_stage;
		done_gain1 |-> conv.start ##1 stage ##1 cal_source == amcs_pkg::SRC_INT_REF;
	endproperty
	a_gain_stage: assert property (p_gain_stage) else $error("second stage missing");

	property p_read_clear;
		result_rd && !set_ready[amcs_pkg::CH_I] |=> !ready[amcs_pkg::CH_I];
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("ready not cleared");

	property p_factory_load;
		state == amcs_pkg::ST_LOAD |=> offset_cal[amcs_pkg::CH_V] == $past(factory_off_v)
			&& gain_cal[amcs_pkg::CH_T] == $past(factory_gain_t);
	endproperty
	a_factory_load: assert property (p_factory_load) else $error("factory load wrong");

	property p_sys_source;
		state == amcs_pkg::ST_BUSY && op[2] && op[1] && !mode_wr |=> cal_source == amcs_pkg::SRC_EXTERNAL;
	endproperty
	a_sys_source: assert property (p_sys_source) else $error("external source off");

	c_single: cover property (done_single);
	c_gain_cal: cover property (done_gain1 ##[1:1000] done_gain2);
	c_sys_full: cover property (done_sf);
	c_abort: cover property (state == amcs_pkg::ST_BUSY && mode_wr);

endmodule

// ==== rtl/amcs_pkg.sv ====
// constants and types shared by the converter mode sequencer
package amcs_pkg;

	// -------------------------------------------------------------
	// mode register layout
	// -------------------------------------------------------------
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int PWR_MSB = 4;
	localparam int PWR_LSB = 3;
	localparam int OP_MSB = 2;
	localparam int OP_LSB = 0;

	// power-mode field codes
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_LOW = 2'h1;
	localparam logic [1:0] PWR_LOWPLUS = 2'h2;

	// operation-mode field codes
	localparam logic [2:0] OP_OFF = 3'h0;
	localparam logic [2:0] OP_CONT = 3'h1;
	localparam logic [2:0] OP_SINGLE = 3'h2;
	localparam logic [2:0] OP_IDLE = 3'h3;
	localparam logic [2:0] OP_SELF_OFFSET = 3'h4;
	localparam logic [2:0] OP_SELF_GAIN = 3'h5;
	localparam logic [2:0] OP_SYS_ZERO = 3'h6;
	localparam logic [2:0] OP_SYS_FULL = 3'h7;

	// current-channel gain codes
	localparam logic [3:0] GAIN_128 = 4'h7;
	localparam logic [3:0] GAIN_512 = 4'h9;

	// calibration input source select
	localparam logic [1:0] SRC_SIGNAL = 2'h0;
	localparam logic [1:0] SRC_INT_ZERO = 2'h1;
	localparam logic [1:0] SRC_INT_REF = 2'h2;
	localparam logic [1:0] SRC_EXTERNAL = 2'h3;

	// -------------------------------------------------------------
	// channels and data
	// -------------------------------------------------------------
	localparam int CH_N = 3;
	localparam int CH_I = 0;
	localparam int CH_V = 1;
	localparam int CH_T = 2;
	localparam int DATA_W = 16;
	localparam logic [15:0] CAL_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_CLK_PERIOD_NS = 1000;
	localparam int CONV_DIV_CYCLES = CONV_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W = $clog2(CONV_DIV_CYCLES);
	localparam int CYC_W = 3;
	localparam logic [2:0] CONV_CYC_PLAIN = 3'h2;
	localparam logic [2:0] CONV_CYC_CHOP = 3'h3;
	localparam logic [2:0] SYS_CAL_CYC = 3'h3;

	typedef enum logic [1:0] {ST_LOAD, ST_STEADY, ST_BUSY} amcs_state_t;

endpackage

// ==== tb/test_adc_mode_calibration_sequencer.sv ====
// self-checking bench for the converter mode and calibration sequencer
`timescale 1ns/1ps
module test_adc_mode_calibration_sequencer;
	typedef struct packed {
		logic [7:0] wd;
		logic [3:0] gp;
		logic [2:0] en;
		logic [3:0] gain;
		logic lp;
		logic rpd;
		logic [2:0] pd;
		logic hold;
	} amcs_row_t;

	logic clk;
	logic reset;
	logic mode_wr;
	logic [7:0] mode_wdata;
	logic [3:0] gain_prog;
	logic chop_en;
	logic [2:0] ch_en;
	logic [2:0][15:0] smp;
	logic [2:0][15:0] sample;
	logic result_rd;
	logic [7:0] mode_reg;
	logic [3:0] eff_gain;
	logic lp_osc_sel;
	logic ref_power_down;
	logic [2:0] conv_power_down;
	logic conv_hold_reset;
	logic conv_active;
	logic [1:0] cal_source;
	logic [2:0][15:0] offset_cal;
	logic [2:0][15:0] gain_cal;
	logic [15:0] current_result;
	logic [2:0] ready;
	logic cal_status;
	int errors;
	int checks;
	int n;
	amcs_row_t rows [6];

	// reference stage reads 0x0100 above the zero stage, so a gain result is a known difference
	assign sample = {smp[2], smp[1],
		smp[0] + ((cal_source == amcs_pkg::SRC_INT_REF) ? 16'h0100 : 16'h0000)};

	amcs_mode_sequencer dut_u (
		.clk(clk),
		.reset(reset),
		.mode_wr(mode_wr),
		.mode_wdata(mode_wdata),
		.gain_prog(gain_prog),
		.chop_en(chop_en),
		.ch_en(ch_en),
		.sample(sample),
		.factory_off_v(16'hA001),
		.factory_gain_v(16'hA002),
		.factory_off_t(16'hA003),
		.factory_gain_t(16'hA004),
		.result_rd(result_rd),
		.mode_reg(mode_reg),
		.eff_gain(eff_gain),
		.lp_osc_sel(lp_osc_sel),
		.ref_power_down(ref_power_down),
		.conv_power_down(conv_power_down),
		.conv_hold_reset(conv_hold_reset),
		.conv_active(conv_active),
		.cal_source(cal_source),
		.offset_cal(offset_cal),
		.gain_cal(gain_cal),
		.current_result(current_result),
		.ready(ready),
		.cal_status(cal_status)
	);

	// -------------------------------------------------------------
	// clock, helpers and verdict
	// -------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] wd);
		@(negedge clk);
		mode_wr = 1'b1;
		mode_wdata = wd;
		@(negedge clk);
		mode_wr = 1'b0;
	endtask

	task automatic rd();
		@(negedge clk);
		result_rd = 1'b1;
		@(negedge clk);
		result_rd = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// counts cycles from the write until the sequencer parks itself in idle
	task automatic run_op(input logic [7:0] wd, input int lo, input int hi);
		wr(wd);
		n = 0;
		while (mode_reg[2:0] !== amcs_pkg::OP_IDLE && n < 4000)
		begin
			@(negedge clk);
			n++;
		end
		checks++;
		if (n < lo || n > hi)
		begin
			errors++;
			$display("CHECK FAILED step length expected %0d..%0d seen %0d", lo, hi, n);
		end
	endtask

	task automatic give_verdict();
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		give_verdict();
	end

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial
	begin
		errors = 0;
		checks = 0;
		reset = 1'b1;
		mode_wr = 1'b0;
		mode_wdata = 8'h00;
		gain_prog = 4'h0;
		chop_en = 1'b0;
		ch_en = 3'h0;
		smp = '0;
		result_rd = 1'b0;
		rows[0] = {8'h00, 4'h3, 3'h7, 4'h3, 1'b0, 1'b1, 3'h7, 1'b0};
		rows[1] = {8'h03, 4'h5, 3'h5, 4'h5, 1'b0, 1'b0, 3'h2, 1'b1};
		rows[2] = {8'h0B, 4'h2, 3'h0, 4'h7, 1'b1, 1'b0, 3'h7, 1'b1};
		rows[3] = {8'h13, 4'h2, 3'h0, 4'h9, 1'b0, 1'b0, 3'h7, 1'b1};
		rows[4] = {8'hE3, 4'hC, 3'h7, 4'hC, 1'b0, 1'b0, 3'h0, 1'b1};
		rows[5] = {8'h10, 4'h1, 3'h7, 4'h9, 1'b0, 1'b1, 3'h7, 1'b0};
		repeat (4) @(negedge clk);
		chk("mode_reg", 16'h0000, 16'(mode_reg));
		chk("ref_power_down", 16'h0001, 16'(ref_power_down));
		chk("conv_power_down", 16'h0007, 16'(conv_power_down));
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		chk("offset_cal v", 16'hA001, offset_cal[1]);
		chk("gain_cal v", 16'hA002, gain_cal[1]);
		chk("offset_cal t", 16'hA003, offset_cal[2]);
		chk("gain_cal t", 16'hA004, gain_cal[2]);
		chk("offset_cal i", 16'h0000, offset_cal[0]);

		// static decode of the power and operation fields
		foreach (rows[i])
		begin
			ch_en = rows[i].en;
			gain_prog = rows[i].gp;
			wr(rows[i].wd);
			repeat (2) @(negedge clk);
			chk("mode_reg", 16'(rows[i].wd), 16'(mode_reg));
			chk("eff_gain", 16'(rows[i].gain), 16'(eff_gain));
			chk("lp_osc_sel", 16'(rows[i].lp), 16'(lp_osc_sel));
			chk("ref_power_down", 16'(rows[i].rpd), 16'(ref_power_down));
			chk("conv_power_down", 16'(rows[i].pd), 16'(conv_power_down));
			chk("conv_hold_reset", 16'(rows[i].hold), 16'(conv_hold_reset));
			chk("conv_active", 16'h0000, 16'(conv_active));
		end

		// single conversion, plain and chopped
		ch_en = 3'h1;
		smp[0] = 16'h1234;
		run_op(8'h02, 500, 504);
		chop_en = 1'b1;
		run_op(8'h02, 750, 754);
		chk("ready", 16'h0001, 16'(ready));
		chk("current_result", 16'h1234, current_result);
		rd();
		chk("ready", 16'h0000, 16'(ready));

		// continuous conversion never parks itself
		chop_en = 1'b0;
		smp[0] = 16'h2222;
		wr(8'h01);
		repeat (1100) @(negedge clk);
		chk("mode_reg", 16'h0001, 16'(mode_reg));
		chk("conv_active", 16'h0001, 16'(conv_active));
		chk("current_result", 16'h2222, current_result);
		wr(8'h03);
		repeat (3) @(negedge clk);
		chk("conv_active", 16'h0000, 16'(conv_active));
		rd();

		// self offset on two channels, temperature left alone
		ch_en = 3'h3;
		smp = {16'h0000, 16'h0B0B, 16'h0A0A};
		run_op(8'h04, 500, 504);
		chk("offset_cal i", 16'h0A0A, offset_cal[0]);
		chk("offset_cal v", 16'h0B0B, offset_cal[1]);
		chk("offset_cal t", 16'hA003, offset_cal[2]);
		chk("cal_status", 16'h0001, 16'(cal_status));
		chk("ready", 16'h0003, 16'(ready));
		rd();

		// self gain: two stages, result is reference minus zero
		ch_en = 3'h1;
		smp[0] = 16'h0300;
		run_op(8'h05, 1000, 1008);
		chk("gain_cal i", 16'h0100, gain_cal[0]);
		chk("cal_status", 16'h0001, 16'(cal_status));
		chk("ready", 16'h0001, 16'(ready));
		rd();

		// system calibrations take three cycles even without chopping
		ch_en = 3'h5;
		smp = {16'h0C0C, 16'h0000, 16'h0D0D};
		run_op(8'h06, 750, 754);
		chk("offset_cal i", 16'h0D0D, offset_cal[0]);
		chk("offset_cal t", 16'h0C0C, offset_cal[2]);
		chk("ready", 16'h0005, 16'(ready));
		run_op(8'h07, 750, 754);
		chk("gain_cal t", 16'h0C0C, gain_cal[2]);
		chk("gain_cal v", 16'hA002, gain_cal[1]);
		chk("cal_status", 16'h0001, 16'(cal_status));
		rd();

		// a write in mid-step aborts it and drops the result
		ch_en = 3'h1;
		wr(8'h02);
		repeat (100) @(negedge clk);
		chk("cal_source", 16'(amcs_pkg::SRC_SIGNAL), 16'(cal_source));
		wr(8'h04);
		repeat (10) @(negedge clk);
		chk("cal_source", 16'(amcs_pkg::SRC_INT_ZERO), 16'(cal_source));
		wr(8'h06);
		repeat (10) @(negedge clk);
		chk("cal_source", 16'(amcs_pkg::SRC_EXTERNAL), 16'(cal_source));
		wr(8'h0B);
		repeat (3) @(negedge clk);
		chk("conv_active", 16'h0000, 16'(conv_active));
		chk("cal_status", 16'h0000, 16'(cal_status));
		chk("ready", 16'h0000, 16'(ready));
		ch_en = 3'h0;
		wr(8'h01);
		repeat (10) @(negedge clk);
		chk("conv_active", 16'h0000, 16'(conv_active));

		// second reset in mid-run
		ch_en = 3'h1;
		repeat (50) @(negedge clk);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		chk("mode_reg", 16'h0000, 16'(mode_reg));
		chk("conv_active", 16'h0000, 16'(conv_active));
		chk("offset_cal i", 16'h0000, offset_cal[0]);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		give_verdict();
	end
endmodule
